// file: midt_pkg.sv
package midt_pkg;

  // APB register byte offsets
  localparam logic [7:0] MIDT_REG_CTRL  = 8'h00;
  localparam logic [7:0] MIDT_REG_STAT  = 8'h04;
  localparam logic [7:0] MIDT_REG_INSN  = 8'h08;
  localparam logic [7:0] MIDT_REG_FIELD = 8'h0c;
  localparam logic [7:0] MIDT_REG_PC    = 8'h10;

  // Control register fields
  localparam int MIDT_CTRL_GIE  = 0;
  localparam int MIDT_CTRL_OSC  = 1;
  localparam int MIDT_CTRL_CP   = 3;
  localparam logic [1:0] MIDT_OSC_RST = 2'h1;
  localparam logic [1:0] MIDT_CP_RST  = 2'h3;
  localparam logic [1:0] MIDT_CP_OFF  = 2'h3;

  // Oscillator modes
  localparam logic [1:0] MIDT_OSC_LP = 2'h0;
  localparam logic [1:0] MIDT_OSC_XT = 2'h1;
  localparam logic [1:0] MIDT_OSC_HS = 2'h2;
  localparam logic [1:0] MIDT_OSC_RC = 2'h3;

  // Instruction word layout
  localparam int MIDT_WORD_W = 14;
  localparam int MIDT_PC_W   = 13;
  localparam int MIDT_PADR_W = 14;
  localparam logic [6:0]  MIDT_F_MAX    = 7'h7f;
  localparam logic [6:0]  MIDT_PCL_ADDR = 7'h02;
  localparam logic [6:0]  MIDT_PORT_LO  = 7'h05;
  localparam logic [6:0]  MIDT_PORT_HI  = 7'h07;
  localparam logic [13:0] MIDT_NOP_WORD = 14'h0000;
  localparam logic [12:0] MIDT_IRQ_VEC  = 13'h0004;
  localparam logic [12:0] MIDT_PC_RST   = 13'h0000;
  localparam logic [13:0] MIDT_ID_BASE  = 14'h2000;
  localparam logic [13:0] MIDT_CFG_ADDR = 14'h2000;

  // Instruction cycle timing: pclk is the oscillator
  localparam int MIDT_QUARTERS = 4;
  localparam logic [1:0] MIDT_Q_LAST = 2'(MIDT_QUARTERS - 1);
  localparam int MIDT_OST_TOSC = 1024;
  localparam int MIDT_OST_CYC  = MIDT_OST_TOSC * 1;
  localparam logic [10:0] MIDT_OST_LOAD = 11'(MIDT_OST_CYC - 1);

  // Serial programming frame
  localparam logic [5:0] MIDT_CMD_CFG  = 6'h00;
  localparam logic [5:0] MIDT_CMD_LOAD = 6'h02;
  localparam logic [5:0] MIDT_CMD_READ = 6'h04;
  localparam logic [5:0] MIDT_CMD_INC  = 6'h06;
  localparam logic [5:0] MIDT_CMD_PROG = 6'h08;
  localparam logic [4:0] MIDT_CMD_LAST = 5'h05;
  localparam logic [4:0] MIDT_DAT_LAST = 5'h0f;
  localparam logic [4:0] MIDT_OUT_END  = 5'h10;

  typedef enum logic [1:0] {
    MIDT_CLS_BYTE = 2'h0,
    MIDT_CLS_BIT  = 2'h1,
    MIDT_CLS_CTRL = 2'h2,
    MIDT_CLS_LIT  = 2'h3
  } midt_cls_t;

  typedef enum logic [1:0] {
    MIDT_CORE_RUN   = 2'b00,
    MIDT_CORE_SLEEP = 2'b01,
    MIDT_CORE_OST   = 2'b11
  } midt_core_t;

  typedef enum logic [1:0] {
    MIDT_SER_CMD = 2'b00,
    MIDT_SER_IN  = 2'b01,
    MIDT_SER_OUT = 2'b11
  } midt_ser_t;

endpackage : midt_pkg

// file: midt_field_decode.sv
`timescale 1ns/1ps
module midt_field_decode
  import midt_pkg::*;
(
  // Fetched word
  input  wire logic [13:0] word,
  // Decoded fields
  output midt_cls_t        cls,
  output logic      [5:0]  opcode,
  output logic      [6:0]  f_addr,
  output logic             dest_file,
  output logic      [7:0]  bit_mask,
  output logic      [10:0] literal,
  output logic             is_jump,
  output logic             is_ret,
  output logic             is_sleep,
  output logic             pcl_write,
  output logic             from_pins
);
  always_comb begin
    cls       = midt_cls_t'(word[13:12]);
    opcode    = word[13:8];
    f_addr    = word[6:0];
    dest_file = word[7];
    bit_mask  = 8'h01 << word[9:7];
    literal   = (word[13:12] == 2'h2) ? word[10:0] : {3'h0, word[7:0]};
    is_jump   = (word[13:12] == 2'h2);
    is_ret    = 1'b0;
    is_sleep  = 1'b0;
    // Don't-care positions are folded to zero so both values act alike
    casez (word)
      14'b00_0000_0??0_0000: begin
        opcode = 6'h00;
        f_addr = 7'h00;
      end
      14'b00_0000_0000_100?: is_ret = 1'b1;
      14'b00_0000_0110_0011: is_sleep = 1'b1;
      14'b11_00??_????_????: opcode = 6'h30;
      14'b11_01??_????_????: begin
        opcode = 6'h34;
        is_ret = 1'b1;
      end
      14'b11_110?_????_????: opcode = 6'h3c;
      14'b11_111?_????_????: opcode = 6'h3e;
      default: ;
    endcase
    pcl_write = (word[13:12] == 2'h0) && word[7] && (word[6:0] == MIDT_PCL_ADDR);
    from_pins = !word[13] && (word[6:0] >= MIDT_PORT_LO) && (word[6:0] <= MIDT_PORT_HI)
                && !(word[13:12] == 2'h0 && word[11:8] == 4'h0 && !word[7]);
  end
endmodule : midt_field_decode

// file: midt_core.sv
`timescale 1ns/1ps
module midt_core
  import midt_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Program memory
  output logic      [13:0] pm_addr,
  input  wire logic [13:0] pm_rdata,
  output logic      [13:0] pm_wdata,
  output logic             pm_we,
  // Execution unit
  input  wire logic        exec_skip,
  input  wire logic [12:0] exec_pc_target,
  input  wire logic [1:0]  pc_page,
  input  wire logic        wake_req,
  output logic             insn_strobe,
  output logic      [1:0]  ex_class,
  output logic      [5:0]  ex_opcode,
  output logic      [6:0]  ex_f,
  output logic             ex_dest_file,
  output logic      [7:0]  ex_bit_mask,
  output logic      [10:0] ex_literal,
  output logic             ex_from_pins,
  output logic             irq_vector,
  output logic             asleep,
  // Program/verify pins
  input  wire logic        pv_mode_pin,
  input  wire logic        prog_clk_pin,
  input  wire logic        prog_data_in,
  output logic             prog_data_out,
  output logic             prog_data_oe_n
);
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        global_irq_enable;
    logic [1:0]  osc;
    logic [1:0]  cp;
    logic [1:0]  pv_s;
    logic [2:0]  ck_s;
    logic [1:0]  dt_s;
    midt_ser_t   ser;
    logic [4:0]  bits;
    logic [15:0] sh;
    logic [13:0] paddr_pv;
    logic [13:0] pm_addr;
    logic [13:0] pm_wdata;
    logic        pm_we;
    logic        dout;
    logic        doe_n;
    midt_core_t  core;
    logic [1:0]  phase;
    logic [10:0] ost;
    logic        vec_pend;
    logic [12:0] pc;
    logic [13:0] ir;
    logic        strobe;
    logic        irq_vec;
    midt_cls_t   cls;
    logic [5:0]  opcode;
    logic [6:0]  f;
    logic        dfile;
    logic [7:0]  mask;
    logic [10:0] lit;
    logic        pins;
    logic        jmp;
    logic        ret;
    logic        slp;
    logic        pclw;
    logic        asleep;
  } midt_state_t;

  midt_state_t q;
  midt_state_t d;

  midt_cls_t   dc_cls;
  logic [5:0]  dc_op;
  logic [6:0]  dc_f;
  logic        dc_d;
  logic [7:0]  dc_mask;
  logic [10:0] dc_lit;
  logic        dc_jmp;
  logic        dc_ret;
  logic        dc_slp;
  logic        dc_pclw;
  logic        dc_pins;
  logic        flush_now;
  logic        protect_now;
  logic        ck_rise;
  logic [5:0]  cmd_now;

  midt_field_decode u_dec (
    .word      (pm_rdata),
    .cls       (dc_cls),
    .opcode    (dc_op),
    .f_addr    (dc_f),
    .dest_file (dc_d),
    .bit_mask  (dc_mask),
    .literal   (dc_lit),
    .is_jump   (dc_jmp),
    .is_ret    (dc_ret),
    .is_sleep  (dc_slp),
    .pcl_write (dc_pclw),
    .from_pins (dc_pins)
  );

  // The instruction in flight alters flow, its skip test came true, or a wake vector is pending
  assign flush_now   = q.jmp || q.ret || q.pclw || exec_skip || q.vec_pend;
  assign protect_now = (q.cp != MIDT_CP_OFF) && (q.paddr_pv < MIDT_ID_BASE);
  assign ck_rise     = q.ck_s[1] && !q.ck_s[2];
  assign cmd_now     = {q.dt_s[1], q.sh[15:11]};

  always_comb begin
    d         = q;
    d.pready  = 1'b0;
    d.pslverr = 1'b0;
    d.pm_we   = 1'b0;
    d.strobe  = 1'b0;
    d.irq_vec = 1'b0;
    // Pins arrive from the programmer's domain
    d.pv_s = {q.pv_s[0], pv_mode_pin};
    d.ck_s = {q.ck_s[1:0], prog_clk_pin};
    d.dt_s = {q.dt_s[0], prog_data_in};

    // Read data is captured in setup so it stands for the whole access phase
    if (psel && !penable) begin
      d.pready = 1'b1;
      d.prdata = 32'h0;
      if (paddr == MIDT_REG_CTRL) begin
        d.prdata[4:0] = {q.cp, q.osc, q.global_irq_enable};
      end else if (paddr == MIDT_REG_STAT) begin
        d.prdata[7:0] = {q.ser, q.phase, q.core, q.pv_s[1], q.vec_pend};
      end else if (paddr == MIDT_REG_INSN) begin
        d.prdata[13:0] = q.ir;
      end else if (paddr == MIDT_REG_FIELD) begin
        d.prdata[29:0] = {q.pins, q.lit, q.mask, q.dfile, q.f, q.cls};
      end else if (paddr == MIDT_REG_PC) begin
        d.prdata[12:0] = q.pc;
      end else begin
        d.pslverr = 1'b1;
      end
    end
    if (psel && penable && q.pready && pwrite && paddr == MIDT_REG_CTRL) begin
      d.global_irq_enable = pwdata[MIDT_CTRL_GIE];
      d.osc = pwdata[MIDT_CTRL_OSC +: 2];
      d.cp  = pwdata[MIDT_CTRL_CP +: 2];
    end

    if (q.pv_s[1]) begin
      // Core is held while the programmer owns the memory
      d.core  = MIDT_CORE_RUN;
      d.phase = 2'h0;
      d.pc    = MIDT_PC_RST;
      if (ck_rise) begin
        d.bits = q.bits + 5'h01;
        d.sh   = {q.dt_s[1], q.sh[15:1]};
        case (q.ser)
          MIDT_SER_CMD: begin
            if (q.bits == MIDT_CMD_LAST) begin
              d.bits = 5'h00;
              if (cmd_now == MIDT_CMD_CFG) begin
                d.paddr_pv = MIDT_CFG_ADDR;
              end else if (cmd_now == MIDT_CMD_LOAD) begin
                d.ser = MIDT_SER_IN;
              end else if (cmd_now == MIDT_CMD_READ) begin
                d.ser = MIDT_SER_OUT;
                // Protected array reads back as zero; ID words stay visible
                d.sh  = {1'b0, protect_now ? 14'h0 : pm_rdata, 1'b0};
              end else if (cmd_now == MIDT_CMD_INC) begin
                d.paddr_pv = q.paddr_pv + 14'h0001;
              end else if (cmd_now == MIDT_CMD_PROG) begin
                d.pm_we = 1'b1;
              end
            end
          end
          MIDT_SER_IN: begin
            if (q.bits == MIDT_DAT_LAST) begin
              d.pm_wdata = d.sh[14:1];
              d.ser      = MIDT_SER_CMD;
              d.bits     = 5'h00;
            end
          end
          default: begin
            d.sh = {1'b0, q.sh[15:1]};
            if (q.bits == MIDT_OUT_END) begin
              d.doe_n = 1'b1;
              d.ser   = MIDT_SER_CMD;
              d.bits  = 5'h00;
            end else begin
              d.dout  = q.sh[0];
              d.doe_n = 1'b0;
            end
          end
        endcase
      end
    end else begin
      d.ser   = MIDT_SER_CMD;
      d.bits  = 5'h00;
      d.doe_n = 1'b1;
      case (q.core)
        MIDT_CORE_RUN: begin
          d.phase = q.phase + 2'h1;
          if (q.phase == MIDT_Q_LAST) begin
            d.strobe = 1'b1;
            if (q.vec_pend) begin
              d.pc       = MIDT_IRQ_VEC;
              d.vec_pend = 1'b0;
              d.irq_vec  = 1'b1;
            end else if (q.jmp) begin
              d.pc = {pc_page, q.lit};
            end else if (q.ret || q.pclw) begin
              d.pc = exec_pc_target;
            end else begin
              d.pc = q.pc + 13'h0001;
            end
            if (flush_now) begin
              // Prefetched word is dropped and a NOP runs in its place
              d.ir   = MIDT_NOP_WORD;
              d.cls  = MIDT_CLS_BYTE;
              d.opcode = 6'h00;
              d.f    = 7'h00;
              d.dfile = 1'b0;
              d.mask = 8'h01;
              d.lit  = 11'h000;
              d.pins = 1'b0;
              d.jmp  = 1'b0;
              d.ret  = 1'b0;
              d.slp  = 1'b0;
              d.pclw = 1'b0;
            end else begin
              d.ir   = pm_rdata;
              d.cls  = dc_cls;
              d.opcode = dc_op;
              d.f    = dc_f;
              d.dfile = dc_d;
              d.mask = dc_mask;
              d.lit  = dc_lit;
              d.pins = dc_pins;
              d.jmp  = dc_jmp;
              d.ret  = dc_ret;
              d.slp  = dc_slp;
              d.pclw = dc_pclw;
            end
            // The word after the sleep is already fetched and waits in ir
            if (q.slp) begin
              d.core = MIDT_CORE_SLEEP;
            end
          end
        end
        MIDT_CORE_SLEEP: begin
          if (wake_req) begin
            d.vec_pend = q.global_irq_enable;
            if (q.osc == MIDT_OSC_RC) begin
              d.core = MIDT_CORE_RUN;
            end else begin
              d.core = MIDT_CORE_OST;
              d.ost  = MIDT_OST_LOAD;
            end
          end
        end
        default: begin
          d.ost = q.ost - 11'h001;
          if (q.ost == 11'h000) begin
            d.core = MIDT_CORE_RUN;
          end
        end
      endcase
    end
    // Upper address bit only reachable from the programmer path
    // Only the settled synchroniser stage steers the address
    d.pm_addr = q.pv_s[1] ? d.paddr_pv : {1'b0, d.pc};
    d.asleep  = (d.core != MIDT_CORE_RUN);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q          <= '0;
      q.osc      <= MIDT_OSC_RST;
      q.cp       <= MIDT_CP_RST;
      q.doe_n    <= 1'b1;
      q.mask     <= 8'h01;
    end else if (ce) begin
      q <= d;
    end
  end

  assign prdata         = q.prdata;
  assign pready         = q.pready;
  assign pslverr        = q.pslverr;
  assign pm_addr        = q.pm_addr;
  assign pm_wdata       = q.pm_wdata;
  assign pm_we          = q.pm_we;
  assign insn_strobe    = q.strobe;
  assign ex_class       = q.cls;
  assign ex_opcode      = q.opcode;
  assign ex_f           = q.f;
  assign ex_dest_file   = q.dfile;
  assign ex_bit_mask    = q.mask;
  assign ex_literal     = q.lit;
  assign ex_from_pins   = q.pins;
  assign irq_vector     = q.irq_vec;
  assign asleep         = q.asleep;
  assign prog_data_out  = q.dout;
  assign prog_data_oe_n = q.doe_n;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic run_q4;
  assign run_q4 = ce && !q.pv_s[1] && q.core == MIDT_CORE_RUN && q.phase == MIDT_Q_LAST;

  fetch_word_a: assert property (run_q4 && !flush_now |=> q.ir == $past(pm_rdata))
    else $error("fetched word not latched");
  dest_sel_a: assert property (q.cls == MIDT_CLS_BYTE |-> q.dfile == q.ir[7])
    else $error("destination bit mismatch");
  file_field_a: assert property (q.cls == MIDT_CLS_BIT |-> q.f == q.ir[6:0])
    else $error("file field mismatch");
  bit_sel_a: assert property (q.cls == MIDT_CLS_BIT |-> q.mask == (8'h01 << q.ir[9:7]))
    else $error("bit mask wrong");
  lit_width_a: assert property (q.cls == MIDT_CLS_CTRL |-> q.lit == q.ir[10:0])
    else $error("branch literal wrong");
  nop_dc_a: assert property (q.ir[13:7] == 7'h00 && q.ir[4:0] == 5'h00 |-> q.opcode == 6'h00)
    else $error("don't-care bits changed nop");
  flush_nop_a: assert property (run_q4 && flush_now |=> q.ir == MIDT_NOP_WORD && !q.jmp)
    else $error("two-cycle slot not a nop");
  quarter_a: assert property (run_q4 |=> q.strobe ##1 !q.strobe [*3])
    else $error("instruction cycle not four periods");
  vec_a: assert property (run_q4 && q.vec_pend |=> q.irq_vec && q.pc == MIDT_IRQ_VEC)
    else $error("wake vector missing");
  rc_wake_a: assert property (ce && q.core == MIDT_CORE_SLEEP && wake_req && !q.pv_s[1]
                              && q.osc == MIDT_OSC_RC |=> q.core == MIDT_CORE_RUN)
    else $error("rc wake delayed");
  ost_load_a: assert property (ce && q.core == MIDT_CORE_SLEEP && wake_req && !q.pv_s[1]
                               && q.osc != MIDT_OSC_RC |=> q.ost == MIDT_OST_LOAD)
    else $error("start-up delay not loaded");
  id_hidden_a: assert property (!q.pv_s[1] && !$past(q.pv_s[1]) |-> !q.pm_addr[13])
    else $error("id space reached in run mode");
  protect_a: assert property (ce && q.pv_s[1] && ck_rise && q.ser == MIDT_SER_CMD
                              && q.bits == MIDT_CMD_LAST && cmd_now == MIDT_CMD_READ
                              && protect_now |=> q.sh[14:1] == 14'h0)
    else $error("protected word leaked");
  pins_a: assert property (q.cls == MIDT_CLS_BIT && q.f == MIDT_PORT_LO |-> q.pins)
    else $error("port read not from pins");

  skip_c: cover property (run_q4 && exec_skip);
  wake_c: cover property (q.core == MIDT_CORE_OST ##1 q.core == MIDT_CORE_RUN);
  vec_c: cover property (q.irq_vec);
  read_c: cover property (!q.doe_n);
endmodule : midt_core

// file: midt_pm_model.sv
`timescale 1ns/1ps
module midt_pm_model
  import midt_pkg::*;
(
  // Clock
  input  wire logic        pclk,
  // Program memory
  input  wire logic [13:0] pm_addr,
  output logic      [13:0] pm_rdata,
  input  wire logic [13:0] pm_wdata,
  input  wire logic        pm_we,
  // Serial pins
  output logic             prog_clk_pin,
  output logic             prog_data_in,
  input  wire logic        prog_data_out,
  input  wire logic        prog_data_oe_n
);
  logic [13:0] mem [0:16383];
  logic        host_en  = 1'b0;
  logic        host_bit = 1'b0;
  logic        last_q   = 1'b0;

  initial begin
    prog_clk_pin = 1'b0;
    foreach (mem[i]) mem[i] = MIDT_NOP_WORD;
  end

  assign pm_rdata = mem[pm_addr];

  always @(posedge pclk) begin
    if (pm_we) mem[pm_addr] <= pm_wdata;
    last_q <= prog_data_in;
  end

  // A released line toggles so a stale bit can never pass as data
  assign prog_data_in = host_en ? host_bit
                      : (!prog_data_oe_n ? prog_data_out : ~last_q);

  // Clock stands low between frames; 8 pclk per half period keeps edges apart
  task automatic tick(input logic drive, input logic b, output logic seen);
    host_en  <= drive;
    host_bit <= b;
    repeat (8) @(posedge pclk);
    prog_clk_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    seen = prog_data_in;
    prog_clk_pin <= 1'b0;
  endtask : tick

  task automatic ser_cmd(input logic [5:0] c);
    logic s;
    for (int i = 0; i < 6; i++) tick(1'b1, c[i], s);
  endtask : ser_cmd

  task automatic ser_word(input logic [15:0] w);
    logic s;
    for (int i = 0; i < 16; i++) tick(1'b1, w[i], s);
  endtask : ser_word

  task automatic ser_read(output logic [15:0] v);
    logic s;
    for (int i = 0; i < 16; i++) tick(1'b0, 1'b0, v[i]);
    tick(1'b0, 1'b0, s);
  endtask : ser_read
endmodule : midt_pm_model

// file: test_mcu_instruction_decode_timing.sv
`timescale 1ns/1ps
module test_mcu_instruction_decode_timing
  import midt_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn, ce, psel, penable, pwrite, pready, pslverr, pm_we;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, d;
  logic [13:0] pm_addr, pm_rdata, pm_wdata;
  logic        exec_skip, wake_req, insn_strobe, ex_dest_file, ex_from_pins, e;
  logic        irq_vector, asleep, pv_mode_pin, prog_clk_pin, prog_data_in;
  logic        prog_data_out, prog_data_oe_n;
  logic [12:0] exec_pc_target;
  logic [1:0]  pc_page, ex_class;
  logic [5:0]  ex_opcode;
  logic [6:0]  ex_f;
  logic [7:0]  ex_bit_mask;
  logic [10:0] ex_literal;
  logic [15:0] v;
  int          mismatches = 0;
  int          num_checks = 0;
  int          n;

  always #2 pclk = ~pclk;

  midt_core DUT (
    .pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pm_addr(pm_addr), .pm_rdata(pm_rdata), .pm_wdata(pm_wdata), .pm_we(pm_we),
    .exec_skip(exec_skip), .exec_pc_target(exec_pc_target), .pc_page(pc_page),
    .wake_req(wake_req), .insn_strobe(insn_strobe), .ex_class(ex_class),
    .ex_opcode(ex_opcode), .ex_f(ex_f), .ex_dest_file(ex_dest_file),
    .ex_bit_mask(ex_bit_mask), .ex_literal(ex_literal), .ex_from_pins(ex_from_pins),
    .irq_vector(irq_vector), .asleep(asleep), .pv_mode_pin(pv_mode_pin),
    .prog_clk_pin(prog_clk_pin), .prog_data_in(prog_data_in),
    .prog_data_out(prog_data_out), .prog_data_oe_n(prog_data_oe_n)
  );

  midt_pm_model pm (
    .pclk(pclk), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .pm_wdata(pm_wdata),
    .pm_we(pm_we), .prog_clk_pin(prog_clk_pin), .prog_data_in(prog_data_in),
    .prog_data_out(prog_data_out), .prog_data_oe_n(prog_data_oe_n)
  );

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) chk("pready", 32'h1, 32'h0);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic next_insn(output int k);
    k = 0;
    do begin
      @(posedge pclk);
      #1;
      k++;
    end while (insn_strobe !== 1'b1 && k < 40);
    chk("strobe", 32'h1, 32'(insn_strobe));
    chk("pm_addr top", 32'h0, 32'(pm_addr[13]));
  endtask : next_insn

  task automatic wait_sleep(input logic lvl, output int k);
    k = 0;
    do begin
      @(posedge pclk);
      #1;
      k++;
    end while (asleep !== lvl && k < 1200);
  endtask : wait_sleep

  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {exec_skip, exec_pc_target, pc_page, wake_req, pv_mode_pin} = '0;
    #1;
    pm.mem[0]  = 14'h07ff;
    pm.mem[1]  = 14'h1385;
    pm.mem[2]  = 14'h33a5;
    pm.mem[3]  = 14'h2810;
    pm.mem[4]  = 14'h0063;
    pm.mem[16] = 14'h0063;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    next_insn(n);
    chk("class", 32'h0, 32'(ex_class));
    chk("opcode", 32'h07, 32'(ex_opcode));
    chk("file", 32'h7f, 32'(ex_f));
    chk("dest", 32'h1, 32'(ex_dest_file));
    next_insn(n);
    chk("gap", 32'h4, 32'(n));
    chk("class", 32'h1, 32'(ex_class));
    chk("mask", 32'h80, 32'(ex_bit_mask));
    chk("from pins", 32'h1, 32'(ex_from_pins));
    next_insn(n);
    chk("opcode", 32'h30, 32'(ex_opcode));
    chk("literal", 32'h0a5, 32'(ex_literal));
    next_insn(n);
    chk("class", 32'h2, 32'(ex_class));
    chk("target", 32'h010, 32'(ex_literal));
    next_insn(n);
    chk("gap", 32'h4, 32'(n));
    chk("flush op", 32'h0, 32'(ex_opcode));
    chk("flush mask", 32'h01, 32'(ex_bit_mask));
    next_insn(n);
    wait_sleep(1'b1, n);
    chk("asleep", 32'h1, 32'(asleep));
    $display("test decode done");
    // Interrupts enabled, RC oscillator: no start-up wait
    apb(1'b1, MIDT_REG_CTRL, 32'h1f, d, e);
    wake_req <= 1'b1;
    wait_sleep(1'b0, n);
    wake_req <= 1'b0;
    chk("rc wake", 32'h1, 32'(n <= 3));
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (irq_vector !== 1'b1 && n < 30);
    chk("vector", 32'h1, 32'(irq_vector));
    chk("vector addr", 32'h0004, 32'(pm_addr));
    wait_sleep(1'b1, n);
    // Interrupts disabled, crystal oscillator
    apb(1'b1, MIDT_REG_CTRL, 32'h1a, d, e);
    wake_req <= 1'b1;
    wait_sleep(1'b0, n);
    wake_req <= 1'b0;
    chk("ost wait", 32'h1, 32'(n >= 1024 && n <= 1028));
    n = 0;
    repeat (24) begin
      @(posedge pclk);
      if (irq_vector === 1'b1) n++;
    end
    chk("no vector", 32'h0, 32'(n));
    $display("test wake done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, MIDT_REG_CTRL, 32'h0, d, e);
    chk("ctrl reset", 32'h1a, d);
    apb(1'b0, 8'h14, 32'h0, d, e);
    chk("unmapped err", 32'h1, 32'(e));
    chk("unmapped data", 32'h0, d);
    $display("test registers done");
    pv_mode_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    pm.ser_cmd(MIDT_CMD_CFG);
    pm.ser_cmd(MIDT_CMD_LOAD);
    pm.ser_word({1'b0, 14'h0005, 1'b0});
    pm.ser_cmd(MIDT_CMD_PROG);
    repeat (8) @(posedge pclk);
    chk("id word", 32'h5, 32'(pm.mem[14'h2000]));
    pm.ser_cmd(MIDT_CMD_READ);
    pm.ser_read(v);
    chk("id read", 32'h5, 32'(v[14:1]));
    chk("released", 32'h1, 32'(prog_data_oe_n));
    $display("test serial done");
    // Reset puts the serial address below the ID space; then protect
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, MIDT_REG_CTRL, 32'h02, d, e);
    pm.ser_cmd(MIDT_CMD_READ);
    pm.ser_read(v);
    chk("protected read", 32'h0, 32'(v[14:1]));
    $display("test protect done");
    test_done();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    test_done();
  end
endmodule : test_mcu_instruction_decode_timing
